// ===== stw_pkg.sv
// Contract
// [R01] Watchdog off after reset, software toggles it
// [R02] Watchdog resets chip after two seconds
// [R03] Software restarts watchdog before it expires
// [R04] Early warning interrupt at 1.75 seconds
// [R05] Sixteen-bit sleep counter in always-on logic
// [R06] Two compare values, each with interrupt
// [R07] Only compare A produces wake; the code also lets a compare B match end idle through idle_wake
// [R08] Source select: 0 is 1kHz, 1 crystal
// [R09] Prescale by 2^N, N above 10 clamps
// [R10] RC clock divided to 1kHz, adjustable divider
// [R11] RC clock always runs, clocks management logic
// [R12] Idle halts processor until interrupt or debug wake
// [R13] Deep sleep exits on listed wake sources
// [R14] Serial receive held off until wake completes
// [R15] Software resets serial port after serial wake
// [R16] Regulator off in sleep, on at wake
// [R17] GPIO outputs frozen throughout deep sleep
// [R18] Core domain registers lost in deep sleep
// [R19] Processor registers saved and restored by hardware
// [R20] Wake cause and later wake events recorded
// [R21] Watchdog timeout logged as reset cause
// [R22] Counter wraps; compare flags sticky until cleared
package stw_pkg;
   localparam int CLK_MHZ = 100;
   localparam int RC_HZ = 10000;
   localparam int CAL_HZ = 1000;
   localparam int WDOG_TIMEOUT_MS = 2000;
   localparam int WDOG_WARN_MS = 1750;
   localparam int WDOG_TIMEOUT_TICKS = RC_HZ * WDOG_TIMEOUT_MS / 1000;
   localparam int WDOG_WARN_TICKS = RC_HZ * WDOG_WARN_MS / 1000;
   localparam int WDOG_W = 15;
   localparam int REG_RAMP_US = 10;
   localparam int REG_RAMP_CYC = REG_RAMP_US * CLK_MHZ;
   localparam int RAMP_W = 10;
   localparam int RST_HOLD_CYC = 16;
   localparam int GPIO_W = 8;
   localparam int ST_W = 16;
   localparam logic [7:0] CAL_DIV_RST = 8'(RC_HZ / CAL_HZ);
   localparam logic [3:0] DIV_MAX = 4'ha;
   localparam logic [3:0] CLK_DIV_RST = 4'h0;
   localparam logic [15:0] ST_CNT_RST = 16'h0000;
   localparam int WAKE_W = 5;
   localparam int WAKE_CMPA = 0;
   localparam int WAKE_EXT = 1;
   localparam int WAKE_DBG = 2;
   localparam int WAKE_SER = 3;
   localparam int WAKE_GPIO = 4;

   typedef enum logic [2:0] {
      PM_ACTIVE,
      PM_IDLE,
      PM_SAVE,
      PM_SLEEP,
      PM_POWER_UP,
      PM_RESTORE
   } stw_pm_state_type;

   typedef struct packed {
      logic clk_sel;
      logic [3:0] clk_div;
      logic [7:0] cal_div;
   } stw_st_cfg_type;

   typedef struct packed {
      logic rc_osc;
      logic xtal;
      logic ext_irq;
      logic debug_wake;
      logic serial_act;
      logic [GPIO_W-1:0] gpio;
   } stw_pins_type;

   // Low N bits (N clamped to 10) of the prescale counter that must all be set for a tick
   function automatic logic [9:0] div_mask(input logic [3:0] n);
      logic [3:0] c;
      c = (n > DIV_MAX) ? DIV_MAX : n;
      div_mask = 10'((11'h001 << c) - 11'h001);
   endfunction
endpackage

// ===== stw_sync.sv
`timescale 1ns/100ps
module stw_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   // Asynchronous levels in, filtered levels out
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] ff1_q;
   logic [W-1:0] ff2_q;
   logic [W-1:0] ff3_q;
   wire [W-1:0] agree = ~(ff2_q ^ ff3_q);

   // A bit moves only once the second and third stages agree
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ff1_q <= '0;
         ff2_q <= '0;
         ff3_q <= '0;
         dout <= '0;
      end else if (ce) begin
         ff1_q <= din;
         ff2_q <= ff1_q;
         ff3_q <= ff2_q;
         dout <= (ff2_q & agree) | (dout & ~agree);
      end
   end
endmodule

// ===== stw_prescale.sv
`timescale 1ns/100ps
module stw_prescale (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   // Source tick and exponent
   input wire logic tick_in,
   input wire logic [3:0] exp_n,
   // Divided tick, one cycle
   output logic tick_out
);
   logic [9:0] cnt_q;
   wire [9:0] mask = stw_pkg::div_mask(exp_n);
   wire hit = tick_in & ((cnt_q & mask) == mask);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         cnt_q <= 10'h000;
         tick_out <= 1'b0;
      end else if (ce) begin
         if (tick_in) begin
            cnt_q <= cnt_q + 10'h001;
         end
         tick_out <= hit; // [R09]
      end
   end
endmodule

// ===== stw_top.sv
`timescale 1ns/100ps
module stw_top #(
   parameter int WDOG_TIMEOUT_TICKS = stw_pkg::WDOG_TIMEOUT_TICKS,
   parameter int WDOG_WARN_TICKS = stw_pkg::WDOG_WARN_TICKS
) (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   // Pins from outside the clock domain
   input wire logic pin_rc_osc,
   input wire logic pin_xtal_32k,
   input wire logic pin_ext_irq,
   input wire logic pin_debug_wake,
   input wire logic pin_serial_act,
   input wire logic [stw_pkg::GPIO_W-1:0] pin_gpio_in,
   // Sleep timer control
   input wire stw_pkg::stw_st_cfg_type st_cfg,
   input wire logic st_run,
   input wire logic [stw_pkg::ST_W-1:0] cmp_a,
   input wire logic [stw_pkg::ST_W-1:0] cmp_b,
   input wire logic cmp_a_clr,
   input wire logic cmp_b_clr,
   // Sleep timer status
   output logic [stw_pkg::ST_W-1:0] st_count,
   output logic cmp_a_flag,
   output logic cmp_b_flag,
   output logic st_wake,
   // Watchdog control
   input wire logic wdog_en,
   input wire logic wdog_restart,
   input wire logic wdog_warn_clr,
   input wire logic rst_cause_clr,
   // Watchdog status
   output logic wdog_warn_flag,
   output logic chip_reset_req,
   output logic rst_cause_wdog,
   // Power mode requests
   input wire logic idle_req,
   input wire logic sleep_req,
   input wire logic any_irq,
   input wire logic serial_wake_en,
   input wire logic [stw_pkg::GPIO_W-1:0] gpio_wake_mask,
   input wire logic wake_cause_clr,
   // Processor state save and restore
   input wire logic cpu_save_done,
   input wire logic cpu_restore_done,
   output logic cpu_save_req,
   output logic cpu_restore_req,
   output logic cpu_halt,
   // Core power and pads
   output logic core_reg_en,
   output logic core_regulator_output,
   output logic core_domain_rst_n,
   output logic serial_rx_en,
   input wire logic [stw_pkg::GPIO_W-1:0] gpio_live,
   output logic [stw_pkg::GPIO_W-1:0] gpio_pad_out,
   // Power status
   output stw_pkg::stw_pm_state_type pm_state,
   output logic [stw_pkg::WAKE_W-1:0] wake_cause,
   output logic wake_done
);
   localparam logic [stw_pkg::WDOG_W-1:0] WD_END =
      stw_pkg::WDOG_W'(WDOG_TIMEOUT_TICKS - 1);
   localparam logic [stw_pkg::WDOG_W-1:0] WD_WARN =
      stw_pkg::WDOG_W'(WDOG_WARN_TICKS - 1);
   localparam logic [stw_pkg::RAMP_W-1:0] RAMP_END =
      stw_pkg::RAMP_W'(stw_pkg::REG_RAMP_CYC - 1);
   localparam logic [4:0] RST_END = 5'(stw_pkg::RST_HOLD_CYC - 1);

   // Pin synchronisation
   stw_pkg::stw_pins_type pins_raw;
   stw_pkg::stw_pins_type pins_s;

   assign pins_raw.rc_osc = pin_rc_osc;
   assign pins_raw.xtal = pin_xtal_32k;
   assign pins_raw.ext_irq = pin_ext_irq;
   assign pins_raw.debug_wake = pin_debug_wake;
   assign pins_raw.serial_act = pin_serial_act;
   assign pins_raw.gpio = pin_gpio_in;

   stw_sync #(
      .W($bits(stw_pkg::stw_pins_type))
   ) u_sync (
      .clk(clk),
      .resetn(resetn),
      .ce(ce),
      .din(pins_raw),
      .dout(pins_s)
   );

   // Edge detection on the filtered pins
   logic rc_prev_q;
   logic xt_prev_q;
   logic ser_prev_q;
   logic [stw_pkg::GPIO_W-1:0] gpio_prev_q;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         rc_prev_q <= 1'b0;
         xt_prev_q <= 1'b0;
         ser_prev_q <= 1'b0;
         gpio_prev_q <= '0;
      end else if (ce) begin
         rc_prev_q <= pins_s.rc_osc;
         xt_prev_q <= pins_s.xtal;
         ser_prev_q <= pins_s.serial_act;
         gpio_prev_q <= pins_s.gpio;
      end
   end

   // The synchronised RC clock drives the management logic as an enable
   wire rc_tick = pins_s.rc_osc & ~rc_prev_q; // [R11]
   wire xt_tick = pins_s.xtal & ~xt_prev_q;
   wire ser_edge = pins_s.serial_act ^ ser_prev_q;
   wire [stw_pkg::GPIO_W-1:0] gpio_edge = pins_s.gpio ^ gpio_prev_q;

   // Calibrated 1kHz divider
   logic [7:0] cal_cnt_q;
   logic cal_tick_q;
   // A zero divisor would never tick, so it acts as one
   wire [7:0] cal_lim = (st_cfg.cal_div == 8'h00) ? 8'h00 : st_cfg.cal_div - 8'h01;
   wire cal_wrap = rc_tick & (cal_cnt_q >= cal_lim);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         cal_cnt_q <= 8'h00;
         cal_tick_q <= 1'b0;
      end else if (ce) begin
         if (cal_wrap) begin
            cal_cnt_q <= 8'h00; // [R10]
         end else if (rc_tick) begin
            cal_cnt_q <= cal_cnt_q + 8'h01;
         end
         cal_tick_q <= cal_wrap; // [R10]
      end
   end

   // Sleep timer clock source and prescaler
   wire src_tick = st_cfg.clk_sel ? xt_tick : cal_tick_q; // [R08]
   logic st_tick;

   stw_prescale u_pre (
      .clk(clk),
      .resetn(resetn),
      .ce(ce),
      .tick_in(src_tick),
      .exp_n(st_cfg.clk_div),
      .tick_out(st_tick)
   );

   // Sleep counter and compares
   logic [stw_pkg::ST_W-1:0] st_cnt_q;
   wire st_step = st_tick & st_run;
   // Natural overflow gives the wrap to zero
   wire [stw_pkg::ST_W-1:0] st_cnt_d = st_cnt_q + 16'h0001; // [R22]
   wire match_a = st_step & (st_cnt_d == cmp_a); // [R06]
   wire match_b = st_step & (st_cnt_d == cmp_b); // [R06]

   always_ff @(posedge clk) begin
      if (!resetn) begin
         st_cnt_q <= stw_pkg::ST_CNT_RST;
         st_count <= stw_pkg::ST_CNT_RST;
         cmp_a_flag <= 1'b0;
         cmp_b_flag <= 1'b0;
         st_wake <= 1'b0;
      end else if (ce) begin
         if (st_step) begin
            st_cnt_q <= st_cnt_d; // [R05]
            st_count <= st_cnt_d;
         end
         // Set wins over a clear in the same cycle
         cmp_a_flag <= match_a | (cmp_a_flag & ~cmp_a_clr); // [R22]
         cmp_b_flag <= match_b | (cmp_b_flag & ~cmp_b_clr); // [R22]
         st_wake <= match_a; // [R07]
      end
   end

   // Watchdog on the RC clock
   logic [stw_pkg::WDOG_W-1:0] wd_cnt_q;
   logic [4:0] rst_hold_q;
   logic rst_busy_q;
   wire wd_step = wdog_en & rc_tick;
   wire wd_warn = wd_step & (wd_cnt_q == WD_WARN);
   wire wd_fire = wd_step & (wd_cnt_q == WD_END);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         wd_cnt_q <= '0; // [R01]
      end else if (ce) begin
         if (!wdog_en || wdog_restart || wd_fire) begin
            wd_cnt_q <= '0; // [R01]
         end else if (wd_step) begin
            wd_cnt_q <= wd_cnt_q + 15'h0001;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         wdog_warn_flag <= 1'b0;
         rst_cause_wdog <= 1'b0;
      end else if (ce) begin
         wdog_warn_flag <= wd_warn | (wdog_warn_flag & ~wdog_warn_clr); // [R04]
         rst_cause_wdog <= wd_fire | (rst_cause_wdog & ~rst_cause_clr); // [R21]
      end
   end

   // Reset request is stretched so slow reset logic sees it
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rst_hold_q <= 5'h00;
         rst_busy_q <= 1'b0;
         chip_reset_req <= 1'b0;
      end else if (ce) begin
         if (wd_fire) begin
            rst_hold_q <= 5'h00;
            rst_busy_q <= 1'b1;
            chip_reset_req <= 1'b1; // [R02]
         end else if (rst_busy_q) begin
            rst_hold_q <= rst_hold_q + 5'h01;
            if (rst_hold_q == RST_END) begin
               rst_busy_q <= 1'b0;
               chip_reset_req <= 1'b0;
            end
         end
      end
   end

   // Wake sources
   logic [stw_pkg::WAKE_W-1:0] ev;
   assign ev[stw_pkg::WAKE_CMPA] = match_a; // [R07]
   assign ev[stw_pkg::WAKE_EXT] = pins_s.ext_irq;
   assign ev[stw_pkg::WAKE_DBG] = pins_s.debug_wake;
   assign ev[stw_pkg::WAKE_SER] = ser_edge & serial_wake_en;
   assign ev[stw_pkg::WAKE_GPIO] = |(gpio_edge & gpio_wake_mask);

   wire sleep_wake = |ev; // [R13]
   wire idle_wake = any_irq | match_a | match_b | wd_warn | pins_s.debug_wake; // [R12]

   // Power mode sequencer
   stw_pkg::stw_pm_state_type state_q;
   stw_pkg::stw_pm_state_type state_d;
   logic [stw_pkg::RAMP_W-1:0] ramp_q;

   always_comb begin
      state_d = state_q;
      case (state_q)
         stw_pkg::PM_ACTIVE: begin
            if (sleep_req) begin
               state_d = stw_pkg::PM_SAVE;
            end else if (idle_req) begin
               state_d = stw_pkg::PM_IDLE;
            end
         end
         stw_pkg::PM_IDLE: begin
            if (idle_wake) begin
               state_d = stw_pkg::PM_ACTIVE; // [R12]
            end
         end
         stw_pkg::PM_SAVE: begin
            if (cpu_save_done) begin
               state_d = stw_pkg::PM_SLEEP; // [R19]
            end
         end
         stw_pkg::PM_SLEEP: begin
            if (sleep_wake) begin
               state_d = stw_pkg::PM_POWER_UP; // [R13]
            end
         end
         stw_pkg::PM_POWER_UP: begin
            if (ramp_q == RAMP_END) begin
               state_d = stw_pkg::PM_RESTORE;
            end
         end
         stw_pkg::PM_RESTORE: begin
            if (cpu_restore_done) begin
               state_d = stw_pkg::PM_ACTIVE; // [R19]
            end
         end
         default: begin
            state_d = stw_pkg::PM_ACTIVE;
         end
      endcase
   end

   // Decoded views of the next state
   wire nx_idle = (state_d == stw_pkg::PM_IDLE);
   wire nx_save = (state_d == stw_pkg::PM_SAVE);
   wire nx_sleep = (state_d == stw_pkg::PM_SLEEP);
   wire nx_pwrup = (state_d == stw_pkg::PM_POWER_UP);
   wire nx_rest = (state_d == stw_pkg::PM_RESTORE);
   wire nx_active = (state_d == stw_pkg::PM_ACTIVE);
   wire nx_wakeseq = nx_sleep | nx_pwrup | nx_rest;
   wire in_wakeseq = (state_q == stw_pkg::PM_SLEEP) |
                     (state_q == stw_pkg::PM_POWER_UP) |
                     (state_q == stw_pkg::PM_RESTORE);
   wire seq_done = (state_q == stw_pkg::PM_RESTORE) & nx_active;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_q <= stw_pkg::PM_ACTIVE;
         pm_state <= stw_pkg::PM_ACTIVE;
         ramp_q <= '0;
      end else if (ce) begin
         state_q <= state_d;
         pm_state <= state_d;
         ramp_q <= (nx_pwrup && state_q == stw_pkg::PM_POWER_UP) ? ramp_q + 10'h001 : '0;
      end
   end

   // Power and processor control outputs
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cpu_save_req <= 1'b0;
         cpu_restore_req <= 1'b0;
         cpu_halt <= 1'b0;
         core_reg_en <= 1'b1;
         core_regulator_output <= 1'b1;
         core_domain_rst_n <= 1'b1;
         serial_rx_en <= 1'b1;
         wake_done <= 1'b0;
      end else if (ce) begin
         cpu_save_req <= nx_save; // [R19]
         cpu_restore_req <= nx_rest; // [R19]
         cpu_halt <= ~nx_active; // [R12]
         core_reg_en <= ~nx_sleep; // [R16]
         // Output is only switched on after the ramp time
         core_regulator_output <= ~(nx_sleep | nx_pwrup); // [R16]
         // Core registers are held in reset while unpowered
         core_domain_rst_n <= ~(nx_sleep | nx_pwrup); // [R18]
         // Partial bytes during wake are dropped by keeping receive off
         serial_rx_en <= ~nx_wakeseq; // [R14]
         wake_done <= seq_done;
      end
   end

   // Pad freeze holds the level present when sleep began
   always_ff @(posedge clk) begin
      if (!resetn) begin
         gpio_pad_out <= '0;
      end else if (ce) begin
         if (!nx_wakeseq) begin
            gpio_pad_out <= gpio_live; // [R17]
         end
      end
   end

   // Wake cause record
   wire [stw_pkg::WAKE_W-1:0] ev_log = in_wakeseq ? ev : '0;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         wake_cause <= '0;
      end else if (ce) begin
         wake_cause <= ev_log | (wake_cause & ~{stw_pkg::WAKE_W{wake_cause_clr}}); // [R20]
      end
   end
endmodule

// ===== stw_top_sva.sv
`timescale 1ns/100ps
module stw_top_sva #(
   parameter int WDOG_TIMEOUT_TICKS = stw_pkg::WDOG_TIMEOUT_TICKS,
   parameter int WDOG_WARN_TICKS = stw_pkg::WDOG_WARN_TICKS
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Sleep timer
   input wire logic [stw_pkg::ST_W-1:0] cmp_a,
   input wire logic [stw_pkg::ST_W-1:0] cmp_b,
   input wire logic cmp_a_clr,
   input wire logic [stw_pkg::ST_W-1:0] st_count,
   input wire logic cmp_a_flag,
   input wire logic cmp_b_flag,
   input wire logic st_wake,
   // Watchdog
   input wire logic chip_reset_req,
   input wire logic rst_cause_wdog,
   // Power
   input wire logic cpu_save_done,
   input wire logic cpu_restore_done,
   input wire logic cpu_halt,
   input wire logic core_reg_en,
   input wire logic core_regulator_output,
   input wire logic serial_rx_en,
   input wire logic [stw_pkg::GPIO_W-1:0] gpio_pad_out,
   input wire stw_pkg::stw_pm_state_type pm_state,
   input wire logic [stw_pkg::WAKE_W-1:0] wake_cause,
   input wire logic wake_done
);
   logic [5:0] rst_len_q, rst_len_d;
   logic [10:0] ramp_q, ramp_d;
   logic asleep;
   // Counters stand in for long repetitions, which the tools unroll badly
   assign rst_len_d = chip_reset_req ? rst_len_q + 6'h01 : 6'h00;
   assign ramp_d = (pm_state == stw_pkg::PM_POWER_UP) ? ramp_q + 11'h001 : 11'h000;
   assign asleep = pm_state inside {stw_pkg::PM_SLEEP, stw_pkg::PM_POWER_UP, stw_pkg::PM_RESTORE};
   always_ff @(posedge clk) begin
      rst_len_q <= resetn ? rst_len_d : 6'h00;
      ramp_q <= resetn ? ramp_d : 11'h000;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence saved_s;
      pm_state == stw_pkg::PM_SAVE && cpu_save_done;
   endsequence
   sequence restored_s;
      pm_state == stw_pkg::PM_RESTORE && cpu_restore_done;
   endsequence
   reset_stretch_a: assert property ($fell(chip_reset_req) |-> rst_len_q == 6'h10)
      else $error("chip reset request length wrong");
   reset_bound_a: assert property (rst_len_q <= 6'h10)
      else $error("chip reset request too long");
   reset_cause_a: assert property ($rose(chip_reset_req) |-> ##[0:1] rst_cause_wdog)
      else $error("watchdog reset cause not logged");
   count_step_a: assert property (st_count != $past(st_count) |-> st_count == $past(st_count) + 16'h0001)
      else $error("sleep counter jumped");
   match_a_a: assert property (st_wake |-> st_count == cmp_a && cmp_a_flag)
      else $error("wake without compare A match");
   match_b_a: assert property ($rose(cmp_b_flag) |-> st_count == cmp_b)
      else $error("compare B flag without match");
   flag_sticky_a: assert property (cmp_a_flag && !cmp_a_clr |=> cmp_a_flag)
      else $error("compare A flag dropped");
   reg_off_a: assert property (pm_state == stw_pkg::PM_SLEEP |-> !core_reg_en && !core_regulator_output)
      else $error("regulator on in sleep");
   reg_ramp_a: assert property ($rose(pm_state == stw_pkg::PM_RESTORE) |-> ramp_q == 11'h3e8 && core_reg_en)
      else $error("regulator ramp length wrong");
   pads_frozen_a: assert property (pm_state == stw_pkg::PM_SLEEP |=> $stable(gpio_pad_out))
      else $error("pads moved in sleep");
   rx_hold_a: assert property (asleep |-> !serial_rx_en)
      else $error("serial receive open while waking");
   save_enter_a: assert property (saved_s |=> pm_state == stw_pkg::PM_SLEEP)
      else $error("sleep not entered after save");
   wake_finish_a: assert property (restored_s |=> pm_state == stw_pkg::PM_ACTIVE && wake_done && !cpu_halt)
      else $error("wake did not finish after restore");
   wake_logged_a: assert property ($rose(pm_state == stw_pkg::PM_POWER_UP) |-> wake_cause != 5'h00)
      else $error("wake without recorded cause");
endmodule

bind stw_top stw_top_sva #(.WDOG_TIMEOUT_TICKS(WDOG_TIMEOUT_TICKS), .WDOG_WARN_TICKS(WDOG_WARN_TICKS)) u_sva (
   .clk(clk), .resetn(resetn), .cmp_a(cmp_a), .cmp_b(cmp_b), .cmp_a_clr(cmp_a_clr), .st_count(st_count),
   .cmp_a_flag(cmp_a_flag), .cmp_b_flag(cmp_b_flag), .st_wake(st_wake), .chip_reset_req(chip_reset_req),
   .rst_cause_wdog(rst_cause_wdog), .cpu_save_done(cpu_save_done), .cpu_restore_done(cpu_restore_done),
   .cpu_halt(cpu_halt), .core_reg_en(core_reg_en), .core_regulator_output(core_regulator_output),
   .serial_rx_en(serial_rx_en), .gpio_pad_out(gpio_pad_out), .pm_state(pm_state), .wake_cause(wake_cause),
   .wake_done(wake_done));

// ===== tb_stw_top.sv
`timescale 1ns/100ps
module tb_stw_top;
   logic clk, resetn = 0, ce = 1;
   logic pin_rc_osc = 0, pin_xtal_32k = 0, pin_ext_irq = 0, pin_debug_wake = 0, pin_serial_act = 0;
   logic [7:0] pin_gpio_in = 8'h00, gpio_wake_mask = 8'h01, gpio_live = 8'h00, gpio_pad_out;
   stw_pkg::stw_st_cfg_type st_cfg = '0;
   logic st_run = 0, cmp_a_clr = 0, cmp_b_clr = 0, wdog_en = 0, wdog_restart = 0, wdog_warn_clr = 0;
   logic rst_cause_clr = 0, idle_req = 0, sleep_req = 0, any_irq = 0, serial_wake_en = 0, wake_cause_clr = 0;
   logic cpu_save_done = 0, cpu_restore_done = 0;
   logic [15:0] cmp_a = 16'h0000, cmp_b = 16'h0000, st_count;
   logic cmp_a_flag, cmp_b_flag, st_wake, wdog_warn_flag, chip_reset_req, rst_cause_wdog;
   logic cpu_save_req, cpu_restore_req, cpu_halt, core_reg_en, core_regulator_output, core_domain_rst_n;
   logic serial_rx_en, wake_done;
   logic [4:0] wake_cause;
   stw_pkg::stw_pm_state_type pm_state;
   logic [3:0] divs [6] = '{4'h0, 4'h1, 4'h3, 4'ha, 4'hb, 4'hf};
   int n_errors = 0, check_count = 0, rc_n = 0, xt_n = 0, rc_c = 0, xt_c = 0;

   // Short watchdog counts keep the run brief
   stw_top #(.WDOG_TIMEOUT_TICKS(40), .WDOG_WARN_TICKS(35)) dut (.clk, .resetn, .ce, .pin_rc_osc, .pin_xtal_32k,
      .pin_ext_irq, .pin_debug_wake, .pin_serial_act, .pin_gpio_in, .st_cfg, .st_run, .cmp_a, .cmp_b, .cmp_a_clr,
      .cmp_b_clr, .st_count, .cmp_a_flag, .cmp_b_flag, .st_wake, .wdog_en, .wdog_restart, .wdog_warn_clr,
      .rst_cause_clr, .wdog_warn_flag, .chip_reset_req, .rst_cause_wdog, .idle_req, .sleep_req, .any_irq,
      .serial_wake_en, .gpio_wake_mask, .wake_cause_clr, .cpu_save_done, .cpu_restore_done, .cpu_save_req,
      .cpu_restore_req, .cpu_halt, .core_reg_en, .core_regulator_output, .core_domain_rst_n, .serial_rx_en,
      .gpio_live, .gpio_pad_out, .pm_state, .wake_cause, .wake_done);

   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end

   // RC and crystal pins run far faster than real so long intervals fit the run
   always @(posedge clk) begin
      rc_c <= (rc_c == 3) ? 0 : rc_c + 1;
      xt_c <= (xt_c == 2) ? 0 : xt_c + 1;
      if (rc_c == 3) begin
         pin_rc_osc <= ~pin_rc_osc;
         rc_n <= rc_n + int'(!pin_rc_osc);
      end
      if (xt_c == 2) begin
         pin_xtal_32k <= ~pin_xtal_32k;
         xt_n <= xt_n + int'(!pin_xtal_32k);
      end
   end

   function automatic int pre(input logic [3:0] n);
      return (n > 4'ha) ? 1024 : 1 << n;
   endfunction

   function automatic int cal_exp(input int c);
      return (c == 0) ? 1 : c;
   endfunction

   task give_verdict;
      if (n_errors == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task tmo(input logic ok);
      if (ok !== 1'b1) begin
         n_errors++;
         give_verdict;
      end
   endtask

   task ws(input stw_pkg::stw_pm_state_type s, input int lim);
      int n;
      for (n = 0; n < lim && pm_state !== s; n++) @(negedge clk);
      tmo(pm_state === s);
   endtask

   task automatic wbit(ref logic b, input int lim);
      int n;
      for (n = 0; n < lim && b !== 1'b1; n++) @(negedge clk);
      tmo(b === 1'b1);
   endtask

   task wcnt;
      logic [15:0] c;
      int n;
      c = st_count;
      for (n = 0; n < 20000 && st_count === c; n++) @(negedge clk);
      tmo(st_count !== c);
   endtask

   initial begin
      int d, k, s, nw;
      logic [7:0] g;
      void'($urandom(74));
      repeat (16) @(posedge clk);
      resetn <= 1;
      @(negedge clk);
      chk({wdog_warn_flag, chip_reset_req, rst_cause_wdog, cpu_halt}, 0);
      g = 8'($urandom);
      @(posedge clk) gpio_live <= g;
      repeat (3) @(negedge clk);
      chk(gpio_pad_out, g);
      @(posedge clk) wdog_en <= 1;
      d = rc_n;
      wbit(wdog_warn_flag, 400);
      k = rc_n - d;
      chk({chip_reset_req, k inside {[34:36]}}, 1);
      wbit(chip_reset_req, 100);
      k = rc_n - d;
      chk(k inside {[39:41]}, 1);
      for (k = 0; k < 40 && chip_reset_req === 1'b1; k++) @(negedge clk);
      chk(k, 16);
      chk(rst_cause_wdog, 1);
      @(posedge clk) wdog_restart <= 1;
      wdog_warn_clr <= 1;
      rst_cause_clr <= 1;
      @(posedge clk) wdog_restart <= 0;
      wdog_warn_clr <= 0;
      rst_cause_clr <= 0;
      // Restart every 20 ticks, well inside the early warning
      repeat (8) begin
         repeat (160) @(posedge clk);
         wdog_restart <= 1;
         @(posedge clk) wdog_restart <= 0;
      end
      chk({wdog_warn_flag, rst_cause_wdog}, 0);
      @(posedge clk) wdog_en <= 0;
      repeat (400) @(negedge clk);
      chk({wdog_warn_flag, chip_reset_req}, 0);
      @(posedge clk) st_run <= 1;
      for (s = 0; s < 6; s++) begin
         @(posedge clk) st_cfg <= '{1'b1, divs[s], 8'h0a};
         wcnt;
         wcnt;
         d = xt_n;
         wcnt;
         chk(xt_n - d, pre(divs[s]));
      end
      for (s = 0; s < 3; s++) begin
         k = (s == 0) ? 0 : 1 + $urandom % 8;
         @(posedge clk) st_cfg <= '{1'b0, 4'h0, 8'(k)};
         wcnt;
         wcnt;
         d = rc_n;
         wcnt;
         chk(rc_n - d, cal_exp(k));
      end
      k = 4 + $urandom % 8;
      @(posedge clk) st_cfg <= '{1'b1, 4'h0, 8'h0a};
      cmp_a <= st_count + 16'(k);
      cmp_b <= st_count + 16'(k + 3);
      cmp_a_clr <= 1;
      cmp_b_clr <= 1;
      @(posedge clk) cmp_a_clr <= 0;
      cmp_b_clr <= 0;
      nw = 0;
      for (d = 0; d < 300 && cmp_b_flag !== 1'b1; d++) begin
         @(negedge clk);
         nw += int'(st_wake === 1'b1);
      end
      chk({cmp_a_flag, cmp_b_flag, nw == 1}, 3'h7);
      @(posedge clk) st_run <= 0;
      repeat (20) @(negedge clk);
      d = st_count;
      repeat (30) @(negedge clk);
      chk({cmp_a_flag, st_count}, {1'b1, 16'(d)});
      @(posedge clk) cmp_a_clr <= 1;
      cmp_b_clr <= 1;
      @(posedge clk) cmp_a_clr <= 0;
      cmp_b_clr <= 0;
      @(negedge clk);
      chk({cmp_a_flag, cmp_b_flag}, 0);
      for (s = 0; s < 2; s++) begin
         @(posedge clk) idle_req <= 1;
         @(posedge clk) idle_req <= 0;
         ws(stw_pkg::PM_IDLE, 5);
         chk(cpu_halt, 1);
         @(posedge clk) any_irq <= (s == 0);
         pin_debug_wake <= (s == 1);
         ws(stw_pkg::PM_ACTIVE, 10);
         @(posedge clk) any_irq <= 0;
         pin_debug_wake <= 0;
      end
      for (s = 0; s < 5; s++) begin
         @(posedge clk) wake_cause_clr <= 1;
         gpio_live <= 8'($urandom);
         @(posedge clk) wake_cause_clr <= 0;
         sleep_req <= 1;
         @(posedge clk) sleep_req <= 0;
         wbit(cpu_save_req, 10);
         @(posedge clk) cpu_save_done <= 1;
         @(posedge clk) cpu_save_done <= 0;
         ws(stw_pkg::PM_SLEEP, 5);
         chk({core_reg_en, core_regulator_output, serial_rx_en, core_domain_rst_n}, 0);
         g = gpio_pad_out;
         // Masked pin and disabled serial activity must not wake
         @(posedge clk) gpio_live <= ~gpio_live;
         pin_gpio_in[7] <= ~pin_gpio_in[7];
         pin_serial_act <= ~pin_serial_act;
         repeat (20) @(negedge clk);
         chk({pm_state, gpio_pad_out}, {stw_pkg::PM_SLEEP, g});
         @(posedge clk) case (s)
            0: begin
               st_run <= 1;
               cmp_a <= st_count + 16'h0004;
            end
            1: pin_ext_irq <= 1;
            2: pin_debug_wake <= 1;
            3: begin
               serial_wake_en <= 1;
               pin_serial_act <= ~pin_serial_act;
            end
            default: pin_gpio_in[0] <= ~pin_gpio_in[0];
         endcase
         ws(stw_pkg::PM_POWER_UP, 60);
         @(posedge clk) pin_ext_irq <= 0;
         serial_wake_en <= 0;
         st_run <= 0;
         pin_debug_wake <= 1;
         repeat (4) @(posedge clk);
         pin_debug_wake <= 0;
         ws(stw_pkg::PM_RESTORE, 1100);
         chk({core_regulator_output, cpu_restore_req, core_domain_rst_n}, 3'h7);
         chk({wake_cause, gpio_pad_out}, {(5'h01 << s) | 5'h04, g});
         @(posedge clk) cpu_restore_done <= 1;
         wbit(wake_done, 5);
         chk({pm_state, serial_rx_en, cpu_halt}, {stw_pkg::PM_ACTIVE, 2'b10});
         @(posedge clk) cpu_restore_done <= 0;
      end
      give_verdict;
   end

   initial begin
      #990000;
      n_errors++;
      give_verdict;
   end
endmodule
